// ### cse_pkg.sv
/*
 * cse_pkg: register offsets, field positions, reset values and state codes
 * for the control store error and branch target block.
 * assumes one 8-bit register port and one clock shared by every user.
 */
package cse_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int PTR_W = 6;
	localparam int TGT_N = 5;

	// documented offsets
	localparam logic [ADDR_W-1:0] OFF_ERR = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_START = 8'h2A;
	localparam logic [ADDR_W-1:0] OFF_LOOP = 8'h2C;
	localparam logic [ADDR_W-1:0] OFF_SKIP1 = 8'h2E;
	localparam logic [ADDR_W-1:0] OFF_SKIP2 = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_SKIP3 = 8'h32;
	// block-local control and status registers
	localparam logic [ADDR_W-1:0] OFF_ERR_CLR = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_CFG = 8'h42;
	localparam logic [ADDR_W-1:0] OFF_STATE = 8'h44;

	// error flag bit positions
	localparam int FLG_CMP = 7;
	localparam int FLG_CMPI = 6;
	localparam int FLG_ID = 5;
	localparam int FLG_WRAP = 4;
	localparam int FLG_DPP = 3;
	localparam int FLG_OVUN = 2;
	localparam int FLG_LRC = 1;
	localparam int FLG_FAULT = 0;
	localparam logic [DATA_W-1:0] RETRY_MASK = 8'hE0;

	// configuration bit positions
	localparam int CFG_CMP_EN = 0;
	localparam int CFG_SRC_SEL = 1;
	localparam int CFG_DIAG_LO = 2;
	localparam int CFG_DIAG_HI = 3;
	localparam int CFG_LRC_EN = 5;
	localparam int CFG_SOFT_RST = 7;
	localparam logic [1:0] DIAG_CUR = 2'h1;
	localparam logic [1:0] DIAG_NEXT = 2'h2;

	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
	localparam logic [PTR_W-1:0] PTR_ZERO = 6'h00;
	localparam logic [PTR_W-1:0] PTR_STEP = 6'h01;
	localparam logic [1:0] PAD_ZERO = 2'h0;

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_IDLE = 2'b01,
		ST_ACTIVE = 2'b10,
		ST_ABORT = 2'b11
	} cse_state_t;

	typedef enum logic [2:0] {
		TGT_START = 3'h0,
		TGT_LOOP = 3'h1,
		TGT_SKIP1 = 3'h2,
		TGT_SKIP2 = 3'h3,
		TGT_SKIP3 = 3'h4
	} cse_tgt_t;

	localparam logic [1:0] SKSEL_1 = 2'h0;
	localparam logic [1:0] SKSEL_2 = 2'h1;
	localparam logic [1:0] SKSEL_3 = 2'h2;

endpackage

// ### cse_tgt_if.sv
/*
 * cse_tgt_if: write path into the branch target registers and their
 * stored values back out.
 * assumes the owner drives one write at most per cycle.
 */
`timescale 1ns/10ps
interface cse_tgt_if (
	input wire logic clk,
	input wire logic rst
);
	import cse_pkg::*;
	logic wr;
	cse_tgt_t sel;
	logic [PTR_W-1:0] wdata;
	logic [PTR_W-1:0] ptr [TGT_N];

	modport regs (input clk, input rst, input wr, input sel, input wdata, output ptr);
	modport user (output wr, output sel, output wdata, input ptr);
endinterface

// ### cse_targets.sv
/*
 * cse_targets: the five six-bit branch targets (start, loop, skip 1..3).
 * assumes writes arrive already decoded with the upper two bits dropped.
 */
`timescale 1ns/10ps
module cse_targets
	import cse_pkg::*;
(
	cse_tgt_if.regs tif
);

	genvar gi;
	generate
		for (gi = 0; gi < TGT_N; gi++) begin : g_tgt
			always_ff @(posedge tif.clk or posedge tif.rst) begin
				if (tif.rst) begin
					tif.ptr[gi] <= PTR_ZERO;
				end else if (tif.wr && (int'(tif.sel) == gi)) begin
					tif.ptr[gi] <= tif.wdata; // [R13] [R15] [R16] [R19]
				end
			end
		end
	endgenerate

endmodule

// ### cse_seq_errors.sv
/*
 * cse_seq_errors: sequencer error flags, write-one clears, branch selection
 * (retry, abort, loop, skip) and register read/write over the 8-bit port.
 * assumes all inputs are synchronous to SYS_CLK_IN and that instruction
 * fields are valid whenever INSTR_DONE_IN pulses.
 */
//Contract
//[R1] flags set on their errors, read-only status, all cleared by soft reset
//[R2] writing one to an interrupt status bit clears that flag
//[R3] compare mismatch flags a differing byte when source select and enable set
//[R4] enable set, source select clear: sync failure sets compare-immediate flag
//[R5] header CRC failure sets the header flag
//[R6] retry with compare, immediate or header flag jumps to loop, clears flag
//[R7] fail bit with any examined flag set aborts the sequencer
//[R8] wrap input differing from gate-derived wrap sets loopback flag
//[R9] parity error during disk read sets parity flag; examined under fail
//[R10] FIFO read while empty or write while full sets overrun flag
//[R11] enabled LRC check flags differing check bytes
//[R12] drive fault holds its flag; clear works only after fault removed
//[R13] start register gives first instruction for execution and loading
//[R14] diagnostic modes 1 and 2 read current and next pointer
//[R15] jump enable branches to loop when block count nonzero, no fail errors
//[R16] skip enable branches to skip target chosen by selector 00, 01, 10
//[R17] state reported as reset, idle, active or aborted code
//[R18] stop interrupt raised whenever the sequencer stops on abort
//[R19] unused upper address bits read zero and ignore writes
//[R20] reading status has no side effect on flags
`timescale 1ns/10ps
module cse_seq_errors
	import cse_pkg::*;
(
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic [ADDR_W-1:0] REG_ADDR_IN,
	input wire logic [DATA_W-1:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [DATA_W-1:0] REG_RDATA_OUT,
	input wire logic START_REQ_IN,
	input wire logic INSTR_DONE_IN,
	input wire logic INSTR_RETRY_IN,
	input wire logic INSTR_FAIL_IN,
	input wire logic INSTR_JUMP_IN,
	input wire logic INSTR_SKIP_IN,
	input wire logic [1:0] INSTR_SKIP_SEL_IN,
	input wire logic INSTR_STOP_IN,
	input wire logic BLOCK_CNT_NZ_IN,
	input wire logic CMP_BYTE_IN,
	input wire logic CMP_DIFF_IN,
	input wire logic CMP_SYNC_FAIL_IN,
	input wire logic ID_CRC_FAIL_IN,
	input wire logic WRAP_IN,
	input wire logic WRITE_GATE_IN,
	input wire logic READ_GATE_IN,
	input wire logic ADDRESS_MARK_ENABLE_IN,
	input wire logic DISK_READ_IN,
	input wire logic DISK_PARITY_ERR_IN,
	input wire logic FIFO_RD_IN,
	input wire logic FIFO_WR_IN,
	input wire logic FIFO_EMPTY_IN,
	input wire logic FIFO_FULL_IN,
	input wire logic LRC_CHECK_IN,
	input wire logic [15:0] LRC_GEN_IN,
	input wire logic [15:0] LRC_READ_IN,
	input wire logic DRIVE_FAULT_INPUT_IN,
	output logic [DATA_W-1:0] ERR_FLAGS_OUT,
	output logic [PTR_W-1:0] IPTR_OUT,
	output logic [1:0] SEQUENCER_STATE_CODE_OUT,
	output logic SEQUENCER_STOP_INTERRUPT_OUT
);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	cse_tgt_if tif (.clk(SYS_CLK_IN), .rst(RST_IN));

	cse_targets u_targets (
		.tif(tif.regs)
	);

	logic [DATA_W-1:0] flags;
	logic [DATA_W-1:0] cfg;
	logic [DATA_W-1:0] set_vec;
	logic [DATA_W-1:0] clr_vec;
	logic [PTR_W-1:0] iptr;
	logic [PTR_W-1:0] next_iptr;
	logic [PTR_W-1:0] skip_ptr;
	cse_state_t state;
	cse_state_t next_state;
	logic soft_rst;
	logic cmp_en;
	logic src_sel;
	logic lrc_en;
	logic [1:0] diag;
	logic wr_clr;
	logic step;
	logic do_abort;
	logic do_retry;
	logic do_skip;
	logic do_jump;
	logic wrap_gen;

	assign soft_rst = cfg[CFG_SOFT_RST];
	assign cmp_en = cfg[CFG_CMP_EN];
	assign src_sel = cfg[CFG_SRC_SEL];
	assign lrc_en = cfg[CFG_LRC_EN];
	assign diag = cfg[CFG_DIAG_HI:CFG_DIAG_LO];
	assign wr_clr = REG_WR_IN && hit(REG_ADDR_IN, OFF_ERR_CLR);
	assign step = (state == ST_ACTIVE) && INSTR_DONE_IN && !soft_rst;
	// the gates are all low when the head is idle, so any asserted gate implies wrap
	assign wrap_gen = WRITE_GATE_IN | READ_GATE_IN | ADDRESS_MARK_ENABLE_IN;

	// error detection
	always_comb begin
		set_vec = BYTE_ZERO;
		set_vec[FLG_CMP] = CMP_BYTE_IN && CMP_DIFF_IN && cmp_en && src_sel; // [R3]
		set_vec[FLG_CMPI] = CMP_SYNC_FAIL_IN && cmp_en && !src_sel; // [R4]
		set_vec[FLG_ID] = ID_CRC_FAIL_IN; // [R5]
		set_vec[FLG_WRAP] = WRAP_IN != wrap_gen; // [R8]
		set_vec[FLG_DPP] = DISK_READ_IN && DISK_PARITY_ERR_IN; // [R9]
		set_vec[FLG_OVUN] = (FIFO_RD_IN && FIFO_EMPTY_IN) || (FIFO_WR_IN && FIFO_FULL_IN); // [R10]
		set_vec[FLG_LRC] = LRC_CHECK_IN && lrc_en && (LRC_GEN_IN != LRC_READ_IN); // [R11]
		set_vec[FLG_FAULT] = DRIVE_FAULT_INPUT_IN; // [R12]
	end

	// branch selection; abort outranks retry, retry outranks skip and jump
	always_comb begin
		do_abort = step && INSTR_FAIL_IN && (flags != BYTE_ZERO); // [R7] [R9]
		do_retry = step && !do_abort && INSTR_RETRY_IN && ((flags & RETRY_MASK) != BYTE_ZERO); // [R6]
		do_skip = step && !do_abort && !do_retry && INSTR_SKIP_IN && (INSTR_SKIP_SEL_IN != 2'h3);
		do_jump = step && !do_abort && !do_retry && !do_skip && INSTR_JUMP_IN && BLOCK_CNT_NZ_IN
			&& !(INSTR_FAIL_IN && (flags != BYTE_ZERO)); // [R15]
		unique case (INSTR_SKIP_SEL_IN)
			SKSEL_1: skip_ptr = tif.ptr[TGT_SKIP1]; // [R16]
			SKSEL_2: skip_ptr = tif.ptr[TGT_SKIP2];
			SKSEL_3: skip_ptr = tif.ptr[TGT_SKIP3];
			default: skip_ptr = iptr;
		endcase
		clr_vec = wr_clr ? REG_WDATA_IN : BYTE_ZERO; // [R2]
		if (do_retry) begin
			clr_vec = clr_vec | (flags & RETRY_MASK); // [R6]
		end
	end

	always_comb begin
		next_iptr = iptr;
		next_state = state;
		unique case (state)
			ST_RESET: begin
				if (!soft_rst) begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (START_REQ_IN) begin
					next_state = ST_ACTIVE;
					next_iptr = tif.ptr[TGT_START]; // [R13]
				end
			end
			ST_ACTIVE: begin
				if (do_abort) begin
					next_state = ST_ABORT; // [R7]
				end else if (step && INSTR_STOP_IN) begin
					next_state = ST_IDLE;
				end else if (do_retry || do_jump) begin
					next_iptr = tif.ptr[TGT_LOOP]; // [R6] [R15]
				end else if (do_skip) begin
					next_iptr = skip_ptr; // [R16]
				end else if (step) begin
					next_iptr = PTR_W'(iptr + PTR_STEP);
				end
			end
			ST_ABORT: begin
				next_state = ST_ABORT;
			end
		endcase
		if (soft_rst) begin
			next_state = ST_RESET; // [R17]
		end
	end

	// flags: soft reset clears all, otherwise a set in the clear cycle wins
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			flags <= BYTE_ZERO;
		end else if (soft_rst) begin
			flags <= BYTE_ZERO; // [R1]
		end else begin
			flags <= (flags & ~clr_vec) | set_vec; // [R1] [R2] [R12] [R20]
		end
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state <= ST_RESET;
			iptr <= PTR_ZERO;
		end else begin
			state <= next_state;
			iptr <= next_iptr;
		end
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			SEQUENCER_STOP_INTERRUPT_OUT <= 1'b0;
		end else begin
			SEQUENCER_STOP_INTERRUPT_OUT <= (state != ST_ABORT) && (next_state == ST_ABORT); // [R18]
		end
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cfg <= CFG_RESET;
		end else if (REG_WR_IN && hit(REG_ADDR_IN, OFF_CFG)) begin
			cfg <= REG_WDATA_IN;
		end
	end

	// target writes keep only the pointer bits
	always_comb begin
		tif.wr = REG_WR_IN;
		tif.wdata = REG_WDATA_IN[PTR_W-1:0]; // [R19]
		tif.sel = TGT_START;
		if (hit(REG_ADDR_IN, OFF_START)) begin
			tif.sel = TGT_START;
		end else if (hit(REG_ADDR_IN, OFF_LOOP)) begin
			tif.sel = TGT_LOOP;
		end else if (hit(REG_ADDR_IN, OFF_SKIP1)) begin
			tif.sel = TGT_SKIP1;
		end else if (hit(REG_ADDR_IN, OFF_SKIP2)) begin
			tif.sel = TGT_SKIP2;
		end else if (hit(REG_ADDR_IN, OFF_SKIP3)) begin
			tif.sel = TGT_SKIP3;
		end else begin
			tif.wr = 1'b0;
		end
	end

	// reads are pure: nothing here feeds back into the flags
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			REG_RDATA_OUT <= BYTE_ZERO;
		end else if (REG_RD_IN) begin
			if (hit(REG_ADDR_IN, OFF_ERR)) begin
				REG_RDATA_OUT <= flags; // [R1] [R20]
			end else if (hit(REG_ADDR_IN, OFF_START)) begin
				if (diag == DIAG_CUR) begin
					REG_RDATA_OUT <= {PAD_ZERO, iptr}; // [R14]
				end else if (diag == DIAG_NEXT) begin
					REG_RDATA_OUT <= {PAD_ZERO, next_iptr}; // [R14]
				end else begin
					REG_RDATA_OUT <= {PAD_ZERO, tif.ptr[TGT_START]}; // [R19]
				end
			end else if (hit(REG_ADDR_IN, OFF_LOOP)) begin
				REG_RDATA_OUT <= {PAD_ZERO, tif.ptr[TGT_LOOP]};
			end else if (hit(REG_ADDR_IN, OFF_SKIP1)) begin
				REG_RDATA_OUT <= {PAD_ZERO, tif.ptr[TGT_SKIP1]};
			end else if (hit(REG_ADDR_IN, OFF_SKIP2)) begin
				REG_RDATA_OUT <= {PAD_ZERO, tif.ptr[TGT_SKIP2]};
			end else if (hit(REG_ADDR_IN, OFF_SKIP3)) begin
				REG_RDATA_OUT <= {PAD_ZERO, tif.ptr[TGT_SKIP3]};
			end else if (hit(REG_ADDR_IN, OFF_CFG)) begin
				REG_RDATA_OUT <= cfg;
			end else if (hit(REG_ADDR_IN, OFF_STATE)) begin
				REG_RDATA_OUT <= {6'h00, state}; // [R17]
			end else begin
				REG_RDATA_OUT <= BYTE_ZERO;
			end
		end
	end

	assign ERR_FLAGS_OUT = flags;
	assign IPTR_OUT = iptr;
	assign SEQUENCER_STATE_CODE_OUT = state;

	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);

	cmp_flag_set_a: assert property (CMP_BYTE_IN && CMP_DIFF_IN && cmp_en && src_sel && !soft_rst
		|=> flags[FLG_CMP]) else $error("compare mismatch not flagged"); // [R3]
	cmpi_flag_set_a: assert property (CMP_SYNC_FAIL_IN && cmp_en && !src_sel && !soft_rst
		|=> flags[FLG_CMPI]) else $error("sync failure not flagged"); // [R4]
	id_flag_set_a: assert property (ID_CRC_FAIL_IN && !soft_rst |=> flags[FLG_ID])
		else $error("header crc failure not flagged"); // [R5]
	wrap_flag_set_a: assert property ((WRAP_IN != wrap_gen) && !soft_rst |=> flags[FLG_WRAP])
		else $error("wrap mismatch not flagged"); // [R8]
	ovun_flag_set_a: assert property (FIFO_RD_IN && FIFO_EMPTY_IN && !soft_rst |=> flags[FLG_OVUN])
		else $error("fifo underrun not flagged"); // [R10]
	fault_hold_a: assert property (DRIVE_FAULT_INPUT_IN && !soft_rst |=> flags[FLG_FAULT])
		else $error("drive fault flag dropped while fault high"); // [R12]
	soft_clear_a: assert property (soft_rst |=> flags == BYTE_ZERO && state == ST_RESET)
		else $error("soft reset did not clear flags"); // [R1]
	w1c_clear_a: assert property (wr_clr && REG_WDATA_IN[FLG_ID] && !ID_CRC_FAIL_IN |=> !flags[FLG_ID])
		else $error("write one did not clear flag"); // [R2]
	retry_jump_a: assert property (step && !INSTR_FAIL_IN && !INSTR_STOP_IN && INSTR_RETRY_IN
		&& flags[FLG_ID] && !ID_CRC_FAIL_IN |=> iptr == $past(tif.ptr[TGT_LOOP]) && !flags[FLG_ID])
		else $error("retry jump wrong"); // [R6]
	abort_stop_a: assert property (step && INSTR_FAIL_IN && flags != BYTE_ZERO
		|=> state == ST_ABORT && SEQUENCER_STOP_INTERRUPT_OUT ##1 !SEQUENCER_STOP_INTERRUPT_OUT)
		else $error("fail with errors did not abort once"); // [R7] [R18]
	start_load_a: assert property (state == ST_IDLE && START_REQ_IN && !soft_rst
		|=> state == ST_ACTIVE && iptr == $past(tif.ptr[TGT_START]))
		else $error("start did not load start pointer"); // [R13]
	diag_read_a: assert property (REG_RD_IN && hit(REG_ADDR_IN, OFF_START) && diag == DIAG_CUR
		|=> REG_RDATA_OUT == {PAD_ZERO, $past(iptr)}) else $error("diag read wrong"); // [R14]
	skip_branch_a: assert property (do_skip && INSTR_SKIP_SEL_IN == SKSEL_2 && !INSTR_STOP_IN
		|=> iptr == $past(tif.ptr[TGT_SKIP2])) else $error("skip target wrong"); // [R16]

	retry_seen_c: cover property (do_retry ##1 state == ST_ACTIVE);
	abort_seen_c: cover property (do_abort ##1 SEQUENCER_STOP_INTERRUPT_OUT);
	jump_seen_c: cover property (do_jump);
	skip_seen_c: cover property (do_skip ##[1:8] do_skip);

endmodule

// ### cse_drive_model.sv
/* cse_drive_model: drive-side stand-in making data path events and the fault level.
 * assumes the bench changes the event code at the falling edge. */
`timescale 1ns/10ps
module cse_drive_model (
	input wire logic clk_in,
	input wire logic [3:0] ev_in,
	output logic cmp_byte_out,
	output logic cmp_diff_out,
	output logic sync_fail_out,
	output logic crc_fail_out,
	output logic wrap_out,
	output logic [2:0] gates_out,
	output logic disk_read_out,
	output logic parity_out,
	output logic [3:0] fifo_out,
	output logic lrc_chk_out,
	output logic [15:0] lrc_gen_out,
	output logic [15:0] lrc_read_out,
	output logic fault_out
);
	logic [15:0] pat = 16'h5A3C;
	logic fault_lvl = 1'b0;
	assign fault_out = fault_lvl;
	// fault is a level the drive owns; only the drive takes it away again
	always @(posedge clk_in) begin
		pat <= pat + 16'h01B7;
		if (ev_in == 4'h8)
			fault_lvl <= 1'b1;
		if (ev_in == 4'h9)
			fault_lvl <= 1'b0;
	end
	always_comb begin
		cmp_byte_out = ev_in == 4'h1;
		cmp_diff_out = ev_in == 4'h1;
		sync_fail_out = ev_in == 4'h2;
		crc_fail_out = ev_in == 4'h3;
		disk_read_out = ev_in == 4'h5;
		parity_out = ev_in == 4'h5;
		gates_out = {1'b0, ev_in == 4'h5, 1'b0};
		// sensed wrap follows the gates except when a mismatch is ordered
		wrap_out = (|gates_out) ^ (ev_in == 4'h4);
		fifo_out = {ev_in == 4'h6, ev_in == 4'hA, ev_in != 4'hA, ev_in == 4'hA};
		lrc_chk_out = ev_in == 4'h7;
		lrc_gen_out = pat;
		lrc_read_out = (ev_in == 4'h7) ? pat ^ 16'h0100 : pat;
	end
endmodule

// ### tb_top.sv
/* tb_top: self-checking bench for cse_seq_errors with a drive-side model.
 * assumes a 200 MHz clock and all inputs changed at the falling edge. */
`timescale 1ns/10ps
module tb_top;
	import cse_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, start = 1'b0, done = 1'b0, nz = 1'b0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata, flags;
	logic [4:0] ins = 5'h00;
	logic [1:0] sel = 2'h3, st;
	logic [5:0] iptr, p;
	logic [3:0] ev = 4'h0;
	logic stp, cb, cd, sf, cf, wrp, drd, par, lchk, flt;
	logic [2:0] g;
	logic [3:0] ff;
	logic [15:0] lg, lr, seed = 16'h755C;
	logic [5:0] tgt[5];
	logic [7:0] offs[5] = '{OFF_START, OFF_LOOP, OFF_SKIP1, OFF_SKIP2, OFF_SKIP3};
	logic [3:0] eev[9] = '{4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'h7};
	logic [7:0] ecfg[9] = '{8'h03, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
	logic [7:0] emsk[9] = '{8'h80, 8'h00, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h02};
	int error_cnt = 0, check_count = 0;

	cse_drive_model drv_u (.clk_in(clk), .ev_in(ev), .cmp_byte_out(cb), .cmp_diff_out(cd),
		.sync_fail_out(sf), .crc_fail_out(cf), .wrap_out(wrp), .gates_out(g), .disk_read_out(drd),
		.parity_out(par), .fifo_out(ff), .lrc_chk_out(lchk), .lrc_gen_out(lg), .lrc_read_out(lr),
		.fault_out(flt));
	cse_seq_errors dut_u (.SYS_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .START_REQ_IN(start),
		.INSTR_DONE_IN(done), .INSTR_RETRY_IN(ins[4]), .INSTR_FAIL_IN(ins[3]), .INSTR_JUMP_IN(ins[2]),
		.INSTR_SKIP_IN(ins[1]), .INSTR_SKIP_SEL_IN(sel), .INSTR_STOP_IN(ins[0]), .BLOCK_CNT_NZ_IN(nz),
		.CMP_BYTE_IN(cb), .CMP_DIFF_IN(cd), .CMP_SYNC_FAIL_IN(sf), .ID_CRC_FAIL_IN(cf), .WRAP_IN(wrp),
		.WRITE_GATE_IN(g[2]), .READ_GATE_IN(g[1]), .ADDRESS_MARK_ENABLE_IN(g[0]), .DISK_READ_IN(drd),
		.DISK_PARITY_ERR_IN(par), .FIFO_RD_IN(ff[3]), .FIFO_WR_IN(ff[2]), .FIFO_EMPTY_IN(ff[1]),
		.FIFO_FULL_IN(ff[0]), .LRC_CHECK_IN(lchk), .LRC_GEN_IN(lg), .LRC_READ_IN(lr),
		.DRIVE_FAULT_INPUT_IN(flt), .ERR_FLAGS_OUT(flags), .IPTR_OUT(iptr),
		.SEQUENCER_STATE_CODE_OUT(st), .SEQUENCER_STOP_INTERRUPT_OUT(stp));

	initial forever #2.5 clk = ~clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk_out(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wreg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// read data is registered, so it is settled one falling edge after the strobe
	task chk_reg(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk_out(rdata, e);
	endtask
	task fire(input logic [3:0] e);
		@(negedge clk);
		ev = e;
		@(negedge clk);
		ev = 4'h0;
	endtask
	task pulse_start;
		@(negedge clk);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		p = tgt[0];
		chk_out({st, iptr}, {ST_ACTIVE, p});
	endtask
	// outside the active state only state code and stop pulse are compared
	task step(input logic [4:0] i, input logic [1:0] s, input logic [1:0] es, input logic [5:0] ep);
		@(negedge clk);
		ins = i;
		sel = s;
		done = 1'b1;
		@(negedge clk);
		done = 1'b0;
		ins = 5'h00;
		sel = 2'h3;
		p = ep;
		if (es == ST_ACTIVE)
			chk_out({st, iptr}, {es, ep});
		else
			chk_out({st, 5'h00, stp}, {es, 5'h00, es == ST_ABORT});
	endtask
	task finish_test;
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#20000;
		error_cnt++;
		finish_test;
	end

	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk_out({st, iptr}, {ST_IDLE, 6'h00});
		chk_out(flags, 8'h00);
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			tgt[i] = seed[5:0];
			wreg(offs[i], seed[7:0]);
			chk_reg(offs[i], {2'b00, tgt[i]});
		end
		wreg(OFF_ERR, 8'hFF);
		chk_reg(OFF_ERR, 8'h00);
		chk_reg(8'h50, 8'h00);
		for (int i = 0; i < 9; i++) begin
			wreg(OFF_CFG, ecfg[i]);
			fire(eev[i]);
			chk_out(flags, emsk[i]);
			chk_reg(OFF_ERR, emsk[i]);
			chk_reg(OFF_ERR, emsk[i]);
			wreg(OFF_ERR_CLR, 8'hFF);
			chk_out(flags, 8'h00);
		end
		fire(4'h8);
		@(negedge clk);
		wreg(OFF_ERR_CLR, 8'h01);
		chk_out(flags, 8'h01);
		fire(4'h9);
		wreg(OFF_ERR_CLR, 8'h01);
		chk_out(flags, 8'h00);
		fire(4'h3);
		wreg(OFF_CFG, 8'h80);
		// the soft reset bit lands on the write edge and acts one edge later
		@(negedge clk);
		chk_out({st, flags[5:0]}, {ST_RESET, 6'h00});
		chk_out(flags, 8'h00);
		wreg(OFF_CFG, 8'h00);
		@(negedge clk);
		chk_out({6'h00, st}, {6'h00, ST_IDLE});
		pulse_start;
		step(5'h00, 2'h3, ST_ACTIVE, p + 6'h01);
		for (int s = 0; s < 3; s++)
			step(5'h02, s[1:0], ST_ACTIVE, tgt[2 + s]);
		nz = 1'b1;
		step(5'h04, 2'h3, ST_ACTIVE, tgt[1]);
		nz = 1'b0;
		step(5'h04, 2'h3, ST_ACTIVE, p + 6'h01);
		wreg(OFF_CFG, 8'h04);
		chk_reg(OFF_START, {2'b00, p});
		wreg(OFF_CFG, 8'h08);
		// next pointer only differs from the current one while a step or a start request is in flight
		@(negedge clk);
		addr = OFF_START;
		rd = 1'b1;
		done = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		done = 1'b0;
		chk_out(rdata, {2'b00, p + 6'h01});
		p = p + 6'h01;
		chk_out({st, iptr}, {ST_ACTIVE, p});
		wreg(OFF_CFG, 8'h00);
		nz = 1'b1;
		step(5'h0C, 2'h3, ST_ACTIVE, tgt[1]);
		fire(4'h3);
		step(5'h10, 2'h3, ST_ACTIVE, tgt[1]);
		chk_out(flags, 8'h00);
		step(5'h10, 2'h3, ST_ACTIVE, p + 6'h01);
		step(5'h01, 2'h3, ST_IDLE, 6'h00);
		pulse_start;
		fire(4'h5);
		step(5'h08, 2'h3, ST_ABORT, 6'h00);
		@(negedge clk);
		chk_out({st, 5'h00, stp}, {ST_ABORT, 6'h00});
		chk_reg(OFF_STATE, 8'h03);
		finish_test;
	end
endmodule
